// ==== rtl/adrg_ramp.sv ====
// Acceleration/deceleration ramp generator with Wishbone register slave
// Contract
// - Accel time spans zero to max frequency; decel time max back to zero.
// - After reset and with no selector configured, pair one is active.
// - Two selector inputs pick pairs one to four as a binary code.
// - Nine ramp times take 0.0 to 6000.0 s, reset to 10.0 s.
// - Time unit scales all nine times: 0 gives 0.01 s, 1 gives 0.1 s.
// - Writing unit 0 refused while any time is 600.1 s or more.
// - Fast stop uses its own time; trigger on closure or opening per configuration.
// - Fast stop latches until stopped, input cleared and run command removed.
// - Nonzero switch frequency picks pair one at or above, pair four below.
// - Closed selector inputs override switch frequency pair choice.
// - Four S-curve times 0.00 to 2.50 s; resets 0.20,0.20,0.20,0.00 s.
// - S-curve ramps rate up from zero at start, down to zero at end.
// - Total accel time is ramp time plus half of both S-curve times.
`timescale 1ns/1ps
module adrg_ramp
    import adrg_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Control inputs
    input wire logic run_i,
    input wire logic acc_sel1_i,
    input wire logic acc_sel2_i,
    input wire logic fast_stop_i,
    // Ramp outputs
    output logic [15:0] out_freq_o,
    output logic ramp_busy_o,
    output logic fast_stop_active_o,
    output logic run_enable_o
);

    function automatic logic [3:0] reg_index(input logic [7:0] adr, input logic [7:0] base,
                                             input logic [3:0] count);
        logic [7:0] off;
        off = adr - base;
        if (adr >= base && off[1:0] == 2'b00 && off[7:2] < {2'b00, count}) begin
            return off[5:2];
        end
        return NO_INDEX;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic [15:0] time_reg [9];
    logic [7:0] scurve_reg [4];
    logic unit_reg;
    logic [15:0] switch_freq_reg;
    logic [15:0] max_freq_reg;
    logic [15:0] target_reg;
    logic [3:0] func_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [1:0] pair_reg;
    logic fs_latch_reg;
    logic [15:0] freq_reg;
    logic [39:0] accf_reg;
    adrg_phase_type phase_reg;
    logic [8:0] k_reg;
    logic [15:0] acck_reg;
    logic dir_reg;
    logic [31:0] tick_cnt_reg;
    logic tick;

    logic [3:0] time_sel;
    logic [3:0] sc_sel;
    logic [31:0] rd_cur;
    logic [31:0] lane_mask;
    logic [31:0] wr_val;
    logic wb_req;
    logic wb_wr;
    logic any_long;

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after request, write on the acked edge
    assign wb_req = wb_cyc_i & wb_stb_i;
    assign wb_wr = wb_req & wb_we_i & ack_reg;
    assign time_sel = reg_index(wb_adr_i, REG_TIME_BASE, NUM_TIMES);
    assign sc_sel = reg_index(wb_adr_i, REG_SCURVE_BASE, NUM_SCURVES);
    assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_val = (rd_cur & ~lane_mask) | (wb_dat_i & lane_mask);
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    always_comb begin
        rd_cur = 32'h00000000;
        if (time_sel != NO_INDEX) begin
            rd_cur = {16'h0000, time_reg[time_sel]};
        end else if (sc_sel != NO_INDEX) begin
            rd_cur = {24'h000000, scurve_reg[sc_sel[1:0]]};
        end else begin
            case (wb_adr_i)
                REG_UNIT: rd_cur = {31'h00000000, unit_reg};
                REG_SWITCH_FREQ: rd_cur = {16'h0000, switch_freq_reg};
                REG_MAX_FREQ: rd_cur = {16'h0000, max_freq_reg};
                REG_TARGET: rd_cur = {16'h0000, target_reg};
                REG_FUNC: rd_cur = {28'h0000000, func_reg};
                REG_STATUS: rd_cur = {25'h0000000, dir_reg, phase_reg, run_enable_o,
                                      fs_latch_reg, pair_reg};
                REG_OUT_FREQ: rd_cur = {16'h0000, freq_reg};
                default: rd_cur = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= wb_req & ~ack_reg;
            if (wb_req & ~ack_reg) begin
                dat_reg <= rd_cur;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Setting registers; out-of-range writes are ignored
    generate
        for (genvar i = 0; i < 9; i++) begin : g_time
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    time_reg[i] <= TIME_RST;
                end else if (wb_wr && time_sel == 4'(i) && wr_val[15:0] <= TIME_MAX) begin
                    time_reg[i] <= wr_val[15:0];
                end
            end
        end
        for (genvar j = 0; j < 4; j++) begin : g_scurve
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    scurve_reg[j] <= (j == 3) ? SCURVE_DECEL_END_RST : SCURVE_START_RST;
                end else if (wb_wr && sc_sel == 4'(j) && wr_val[7:0] <= SCURVE_MAX) begin
                    scurve_reg[j] <= wr_val[7:0];
                end
            end
        end
    endgenerate

    always_comb begin
        any_long = 1'b0;
        for (int i = 0; i < 9; i++) begin
            any_long = any_long | (time_reg[i] >= FINE_UNIT_LIMIT);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unit_reg <= UNIT_RST;
            switch_freq_reg <= SWITCH_FREQ_RST;
            max_freq_reg <= MAX_FREQ_RST;
            target_reg <= TARGET_RST;
            func_reg <= FUNC_RST;
        end else if (wb_wr) begin
            if (wb_adr_i == REG_UNIT && (wr_val[0] || !any_long)) begin
                unit_reg <= wr_val[0];
            end
            if (wb_adr_i == REG_SWITCH_FREQ && wr_val[15:0] <= SWITCH_FREQ_MAX) begin
                switch_freq_reg <= wr_val[15:0];
            end
            if (wb_adr_i == REG_MAX_FREQ) begin
                max_freq_reg <= wr_val[15:0];
            end
            if (wb_adr_i == REG_TARGET) begin
                target_reg <= wr_val[15:0];
            end
            if (wb_adr_i == REG_FUNC) begin
                func_reg <= wr_val[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pair selection, fast stop and run gating
    logic sel1_closed;
    logic sel2_closed;
    logic fs_trig;
    logic run_eff;
    logic [15:0] tgt;
    logic going_up;
    logic going_dn;

    assign sel1_closed = func_reg[FN_SEL1] & acc_sel1_i;
    assign sel2_closed = func_reg[FN_SEL2] & acc_sel2_i;
    assign fs_trig = (func_reg[FN_FS_NO] & fast_stop_i) | (func_reg[FN_FS_NC] & ~fast_stop_i);
    assign run_eff = run_i & ~fs_latch_reg & ~fs_trig;
    assign tgt = !run_eff ? 16'h0000 : (target_reg > max_freq_reg ? max_freq_reg : target_reg);
    assign going_up = tgt > freq_reg;
    assign going_dn = tgt < freq_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pair_reg <= 2'b00;
        end else if (sel1_closed | sel2_closed) begin
            pair_reg <= {sel2_closed, sel1_closed};
        end else if (switch_freq_reg != 16'h0000) begin
            pair_reg <= (freq_reg >= switch_freq_reg) ? 2'b00 : 2'b11;
        end else begin
            pair_reg <= 2'b00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fs_latch_reg <= 1'b0;
        end else if (fs_trig) begin
            fs_latch_reg <= 1'b1;
        end else if (freq_reg == 16'h0000 && !run_i) begin
            fs_latch_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Active ramp and S-curve durations in milliseconds
    logic [3:0] time_idx;
    logic [23:0] t_ms;
    logic [11:0] sc_start_ms;
    logic [11:0] sc_end_ms;
    logic [11:0] cur_ms;
    logic [39:0] den;
    logic [39:0] addf;
    logic [15:0] rem;
    logic end_hit;
    logic dir_chg;
    logic kstep;
    logic stepf;

    assign time_idx = (fs_latch_reg && going_dn) ? FAST_STOP_IDX
                      : {1'b0, pair_reg, going_dn};
    assign t_ms = 24'(time_reg[time_idx]) * (unit_reg ? MS_PER_COARSE : MS_PER_FINE);
    assign sc_start_ms = fs_latch_reg ? 12'h000
                         : 12'(scurve_reg[going_dn ? 2 : 0]) * MS_PER_SCURVE;
    assign sc_end_ms = fs_latch_reg ? 12'h000
                       : 12'(scurve_reg[going_dn ? 3 : 1]) * MS_PER_SCURVE;
    assign cur_ms = (phase_reg == PH_END) ? sc_end_ms : sc_start_ms;
    // Full rate moves max frequency per t_ms; k scales it
    assign den = 40'(t_ms) * 40'(RATE_FULL);
    assign addf = 40'(max_freq_reg) * 40'(k_reg);
    assign rem = going_up ? tgt - freq_reg : freq_reg - tgt;
    // Start easing down once remaining span fits the end ramp
    assign end_hit = (sc_end_ms != 12'h000)
        && (64'(rem) * 64'(t_ms) * 64'(2) * 64'(RATE_FULL) * 64'(RATE_FULL)
            <= 64'(max_freq_reg) * 64'(k_reg) * 64'(k_reg) * 64'(sc_end_ms));
    assign dir_chg = (phase_reg != PH_IDLE) && (going_up != dir_reg);
    assign kstep = (cur_ms != 12'h000) && ({4'h0, cur_ms} <= acck_reg)
                   && ((phase_reg == PH_START && k_reg != RATE_FULL)
                       || (phase_reg == PH_END && k_reg > 9'h001));
    assign stepf = accf_reg >= den;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_reg <= 32'h00000000;
            tick <= 1'b0;
        end else begin
            tick <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
            tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h00000000
                            : tick_cnt_reg + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Rate shaping state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= PH_IDLE;
            k_reg <= 9'h000;
            acck_reg <= 16'h0000;
            dir_reg <= 1'b0;
        end else if (freq_reg == tgt || t_ms == 24'h000000) begin
            phase_reg <= PH_IDLE;
            k_reg <= 9'h000;
            acck_reg <= 16'h0000;
        end else if (phase_reg == PH_IDLE || dir_chg
                     || (fs_latch_reg && phase_reg != PH_CRUISE)) begin
            phase_reg <= (sc_start_ms == 12'h000) ? PH_CRUISE : PH_START;
            k_reg <= (sc_start_ms == 12'h000) ? RATE_FULL : 9'h000;
            acck_reg <= 16'h0000;
            dir_reg <= going_up;
        end else if (phase_reg != PH_END && end_hit) begin
            phase_reg <= PH_END;
            acck_reg <= 16'h0000;
        end else if (phase_reg == PH_START && k_reg == RATE_FULL) begin
            phase_reg <= PH_CRUISE;
            acck_reg <= 16'h0000;
        end else if (phase_reg != PH_CRUISE) begin
            acck_reg <= acck_reg + (tick ? 16'(RATE_FULL) : 16'h0000)
                        - (kstep ? {4'h0, cur_ms} : 16'h0000);
            if (kstep) begin
                k_reg <= (phase_reg == PH_START) ? k_reg + 9'h001 : k_reg - 9'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output frequency: one unit per step, straight to the target when t_ms is zero, never past the target
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_reg <= 16'h0000;
            accf_reg <= 40'h0000000000;
        end else if (freq_reg == tgt || dir_chg) begin
            accf_reg <= 40'h0000000000;
        end else if (t_ms == 24'h000000) begin
            freq_reg <= tgt;
            accf_reg <= 40'h0000000000;
        end else begin
            accf_reg <= accf_reg + (tick ? addf : 40'h0000000000)
                        - (stepf ? den : 40'h0000000000);
            if (stepf) begin
                freq_reg <= going_up ? freq_reg + 16'h0001 : freq_reg - 16'h0001;
            end
        end
    end

    assign out_freq_o = freq_reg;
    assign ramp_busy_o = phase_reg != PH_IDLE;
    assign fast_stop_active_o = fs_latch_reg;
    assign run_enable_o = run_eff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_unit_zero_write;
        wb_wr && wb_adr_i == REG_UNIT && !wr_val[0];
    endsequence
    sequence s_no_selector;
        !sel1_closed && !sel2_closed;
    endsequence

    property p_reset_defaults;
        @(posedge clk_i) $fell(rst_i) |-> unit_reg && time_reg[8] == TIME_RST
            && scurve_reg[0] == SCURVE_START_RST && scurve_reg[3] == SCURVE_DECEL_END_RST;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset values");

    property p_pair_inputs;
        @(posedge clk_i) disable iff (rst_i)
            (sel1_closed || sel2_closed) |=> pair_reg == {$past(sel2_closed), $past(sel1_closed)};
    endproperty
    a_pair_inputs: assert property (p_pair_inputs) else $error("selector pair wrong");

    property p_pair_threshold;
        @(posedge clk_i) disable iff (rst_i)
            s_no_selector ##0 (switch_freq_reg != 16'h0000 && freq_reg < switch_freq_reg)
            |=> pair_reg == 2'b11;
    endproperty
    a_pair_threshold: assert property (p_pair_threshold) else $error("threshold pair");

    property p_pair_default;
        @(posedge clk_i) disable iff (rst_i)
            s_no_selector ##0 switch_freq_reg == 16'h0000 |=> pair_reg == 2'b00;
    endproperty
    a_pair_default: assert property (p_pair_default) else $error("default pair");

    property p_unit_refuse;
        @(posedge clk_i) disable iff (rst_i)
            s_unit_zero_write ##0 any_long |=> unit_reg == $past(unit_reg);
    endproperty
    a_unit_refuse: assert property (p_unit_refuse) else $error("unit write not refused");

    property p_fs_hold;
        @(posedge clk_i) disable iff (rst_i)
            fs_latch_reg && (freq_reg != 16'h0000 || run_i) |=> fs_latch_reg;
    endproperty
    a_fs_hold: assert property (p_fs_hold) else $error("fast stop released early");

    property p_fs_trigger;
        @(posedge clk_i) disable iff (rst_i)
            fs_trig |-> !run_enable_o ##1 fast_stop_active_o;
    endproperty
    a_fs_trigger: assert property (p_fs_trigger) else $error("fast stop not latched");

    property p_no_overshoot;
        @(posedge clk_i) disable iff (rst_i)
            (freq_reg <= tgt) ##1 $stable(tgt) |-> freq_reg <= tgt;
    endproperty
    a_no_overshoot: assert property (p_no_overshoot) else $error("frequency overshoot");

    property p_unit_step;
        @(posedge clk_i) disable iff (rst_i)
            t_ms != 24'h000000 && freq_reg != tgt && !dir_chg |=>
            (freq_reg - $past(freq_reg) == 16'h0001 || $past(freq_reg) - freq_reg == 16'h0001
             || freq_reg == $past(freq_reg));
    endproperty
    a_unit_step: assert property (p_unit_step) else $error("step not one unit");

    property p_rate_ramp;
        @(posedge clk_i) disable iff (rst_i)
            phase_reg == PH_START && !dir_chg ##1 phase_reg == PH_START
            |-> k_reg - $past(k_reg) <= 9'h001;
    endproperty
    a_rate_ramp: assert property (p_rate_ramp) else $error("rate jumped");

endmodule

// ==== rtl/adrg_pkg.sv ====
// Constants and types for the acceleration/deceleration ramp generator
package adrg_pkg;
    // Clock and control tick
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES_DEF = (TICK_US * 1000) / CLK_PERIOD_NS;
    // Register byte offsets
    localparam logic [7:0] REG_TIME_BASE = 8'h00;
    localparam logic [7:0] REG_UNIT = 8'h24;
    localparam logic [7:0] REG_SWITCH_FREQ = 8'h28;
    localparam logic [7:0] REG_SCURVE_BASE = 8'h2C;
    localparam logic [7:0] REG_MAX_FREQ = 8'h3C;
    localparam logic [7:0] REG_TARGET = 8'h40;
    localparam logic [7:0] REG_FUNC = 8'h44;
    localparam logic [7:0] REG_STATUS = 8'h48;
    localparam logic [7:0] REG_OUT_FREQ = 8'h4C;
    localparam logic [3:0] NUM_TIMES = 4'h9;
    localparam logic [3:0] NUM_SCURVES = 4'h4;
    localparam logic [3:0] NO_INDEX = 4'hF;
    localparam logic [3:0] FAST_STOP_IDX = 4'h8;
    // Reset values
    localparam logic [15:0] TIME_RST = 16'h0064;
    localparam logic UNIT_RST = 1'b1;
    localparam logic [15:0] SWITCH_FREQ_RST = 16'h0000;
    localparam logic [7:0] SCURVE_START_RST = 8'h14;
    localparam logic [7:0] SCURVE_DECEL_END_RST = 8'h00;
    localparam logic [15:0] MAX_FREQ_RST = 16'h0258;
    localparam logic [15:0] TARGET_RST = 16'h0000;
    localparam logic [3:0] FUNC_RST = 4'h0;
    // Setting limits
    localparam logic [15:0] TIME_MAX = 16'hEA60;
    localparam logic [15:0] FINE_UNIT_LIMIT = 16'h1771;
    localparam logic [15:0] SWITCH_FREQ_MAX = 16'h07D0;
    localparam logic [7:0] SCURVE_MAX = 8'hFA;
    // Unit scaling to milliseconds
    localparam logic [23:0] MS_PER_COARSE = 24'h000064;
    localparam logic [23:0] MS_PER_FINE = 24'h00000A;
    localparam logic [11:0] MS_PER_SCURVE = 12'h00A;
    localparam logic [8:0] RATE_FULL = 9'h100;
    // Input function select bits
    localparam int FN_SEL1 = 0;
    localparam int FN_SEL2 = 1;
    localparam int FN_FS_NO = 2;
    localparam int FN_FS_NC = 3;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_START = 2'b01,
        PH_CRUISE = 2'b10,
        PH_END = 2'b11
    } adrg_phase_type;
endpackage

// ==== sim/adrg_motor_model.sv ====
// Motor control path model watching the ramped frequency
`timescale 1ns/1ps
module adrg_motor_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Ramp side
    input wire logic [15:0] freq_i,
    input wire logic [15:0] limit_i,
    // Observation
    output logic overshoot_o
);
    // Sticky flag once the drive is pushed past the commanded speed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overshoot_o <= 1'b0;
        end else if (freq_i > limit_i) begin
            overshoot_o <= 1'b1;
        end
    end
endmodule

// ==== sim/testbench.sv ====
// Self-checking testbench for the ramp generator
`timescale 1ns/1ps
module testbench;
    import adrg_pkg::*;
    typedef struct packed {
        logic we;
        logic [7:0] adr;
        logic [31:0] wd;
        logic [31:0] exp;
    } adrg_row_type;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic run_i = 1'b0;
    logic acc_sel1_i = 1'b0;
    logic acc_sel2_i = 1'b0;
    logic fast_stop_i = 1'b0;
    logic [15:0] out_freq_o;
    logic ramp_busy_o;
    logic fast_stop_active_o;
    logic run_enable_o;
    logic overshoot;
    int fails = 0;
    int comparisons = 0;
    logic [31:0] q;
    int n;
    // Reset values, range limits, unit refusal and ramp settings
    adrg_row_type rows [0:23] = '{
        '{1'b0, 8'h00, 32'h0, 32'h64}, '{1'b0, 8'h20, 32'h0, 32'h64},
        '{1'b0, 8'h24, 32'h0, 32'h1}, '{1'b0, 8'h28, 32'h0, 32'h0},
        '{1'b0, 8'h2C, 32'h0, 32'h14}, '{1'b0, 8'h30, 32'h0, 32'h14},
        '{1'b0, 8'h34, 32'h0, 32'h14}, '{1'b0, 8'h38, 32'h0, 32'h0},
        '{1'b0, 8'h50, 32'h0, 32'h0}, '{1'b1, 8'h00, 32'hEA61, 32'h64},
        '{1'b1, 8'h00, 32'hEA60, 32'hEA60}, '{1'b1, 8'h24, 32'h0, 32'h1},
        '{1'b1, 8'h00, 32'h1770, 32'h1770}, '{1'b1, 8'h24, 32'h0, 32'h0},
        '{1'b1, 8'h2C, 32'hFB, 32'h14}, '{1'b1, 8'h2C, 32'h0, 32'h0},
        '{1'b1, 8'h30, 32'h0, 32'h0}, '{1'b1, 8'h34, 32'h0, 32'h0},
        '{1'b1, 8'h00, 32'hA, 32'hA}, '{1'b1, 8'h04, 32'hA, 32'hA},
        '{1'b1, 8'h18, 32'hA, 32'hA}, '{1'b1, 8'h20, 32'hA, 32'hA},
        '{1'b1, 8'h48, 32'hFF, 32'h0}, '{1'b1, 8'h40, 32'h12C, 32'h12C}};

    always #25 clk_i = ~clk_i;

    adrg_ramp #(.TICK_CYCLES(20)) adrg_ramp_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_i(run_i), .acc_sel1_i(acc_sel1_i),
        .acc_sel2_i(acc_sel2_i), .fast_stop_i(fast_stop_i), .out_freq_o(out_freq_o),
        .ramp_busy_o(ramp_busy_o), .fast_stop_active_o(fast_stop_active_o),
        .run_enable_o(run_enable_o));
    adrg_motor_model adrg_motor_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .freq_i(out_freq_o), .limit_i(16'h012C),
        .overshoot_o(overshoot));

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Classic single Wishbone cycle, bounded wait for ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 50) begin
            fails++;
            give_verdict();
        end
        @(posedge clk_i);
    endtask

    // Wait until the ramp settles at a frequency
    task automatic wait_freq(input logic [15:0] f, output int k);
        k = 0;
        while (!(out_freq_o === f && ramp_busy_o === 1'b0) && k < 5000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 5000) begin
            fails++;
            give_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].we) begin
                wb(1'b1, rows[i].adr, rows[i].wd, q);
            end
            wb(1'b0, rows[i].adr, 32'h0, q);
            check(q, rows[i].exp);
        end
        // Fine unit: 0.1 s for full scale, half scale in about 50 ticks
        @(posedge clk_i);
        run_i <= 1'b1;
        wait_freq(16'h012C, n);
        check({31'h0, n >= 900 && n <= 1100}, 32'h1);
        repeat (40) @(posedge clk_i);
        check({16'h0, out_freq_o}, 32'h12C);
        // Binary selector code picks the pair
        wb(1'b1, REG_FUNC, 32'h3, q);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            acc_sel1_i <= i[0];
            acc_sel2_i <= i[1];
            repeat (3) @(posedge clk_i);
            wb(1'b0, REG_STATUS, 32'h0, q);
            check({30'h0, q[1:0]}, i);
        end
        acc_sel1_i <= 1'b0;
        acc_sel2_i <= 1'b0;
        wb(1'b1, REG_SWITCH_FREQ, 32'h64, q);
        wb(1'b0, REG_STATUS, 32'h0, q);
        check({30'h0, q[1:0]}, 32'h0);
        acc_sel1_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        wb(1'b0, REG_STATUS, 32'h0, q);
        check({30'h0, q[1:0]}, 32'h1);
        acc_sel1_i <= 1'b0;
        // Brief closure latches a fast stop
        wb(1'b1, REG_FUNC, 32'h7, q);
        fast_stop_i <= 1'b1;
        @(negedge clk_i);
        check({31'h0, run_enable_o}, 32'h0);
        @(posedge clk_i);
        fast_stop_i <= 1'b0;
        @(negedge clk_i);
        check({31'h0, fast_stop_active_o}, 32'h1);
        wait_freq(16'h0000, n);
        repeat (5) @(posedge clk_i);
        check({30'h0, fast_stop_active_o, run_enable_o}, 32'h2);
        run_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({31'h0, fast_stop_active_o}, 32'h0);
        run_i <= 1'b1;
        @(negedge clk_i);
        check({31'h0, run_enable_o}, 32'h1);
        repeat (20) @(posedge clk_i);
        wb(1'b0, REG_STATUS, 32'h0, q);
        check({30'h0, q[1:0]}, 32'h3);
        wait_freq(16'h012C, n);
        check({31'h0, overshoot}, 32'h0);
        // Opening variant triggers when the contact opens
        wb(1'b1, REG_FUNC, 32'h3, q);
        fast_stop_i <= 1'b1;
        wb(1'b1, REG_FUNC, 32'h8, q);
        check({31'h0, run_enable_o}, 32'h1);
        fast_stop_i <= 1'b0;
        @(negedge clk_i);
        check({31'h0, run_enable_o}, 32'h0);
        // Second reset in mid-run restores defaults
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        fast_stop_i <= 1'b0;
        wb(1'b0, REG_UNIT, 32'h0, q);
        check(q, 32'h1);
        wb(1'b0, REG_TIME_BASE, 32'h0, q);
        check(q, 32'h64);
        wb(1'b0, REG_STATUS, 32'h0, q);
        check({30'h0, q[1:0]}, 32'h0);
        check({16'h0, out_freq_o}, 32'h0);
        // Start shaping only: 50 ms linear half ramp plus 25 ms, about 1500 cycles
        wb(1'b1, REG_TIME_BASE, 32'h1, q);
        wb(1'b1, REG_SCURVE_BASE, 32'h5, q);
        wb(1'b1, 8'h30, 32'h0, q);
        wb(1'b1, REG_TARGET, 32'h12C, q);
        wait_freq(16'h012C, n);
        check({31'h0, n >= 1400 && n <= 1650}, 32'h1);
        check({31'h0, overshoot}, 32'h0);
        give_verdict();
    end
endmodule
